// File: rtl/interrupt_vector_table_select.sv
// vector fetch address generator with alternate table and reset entry
// assumes the core presents one arbitrated service request at a time
module interrupt_vector_table_select
  import vector_table_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ctrl_write,
  input  wire logic [15:0]       interrupt_control_two,
  input  wire logic [NUM_IRQ-1:0] irq_pending,
  input  wire logic [7:0]        trap_pending,
  input  wire logic              service_req,
  input  wire logic              entry_valid,
  input  wire logic [ADDR_W-1:0] entry_data,
  output logic                   alt_table_select,
  output logic      [ADDR_W-1:0] fetch_addr,
  output logic                   fetch_req,
  output logic      [ADDR_W-1:0] pc,
  output logic                   pc_load,
  output logic      [7:0]        vector_num,
  output logic                   busy
);
  typedef enum logic [1:0] {ST_RESET_JUMP, ST_IDLE, ST_FETCH} state_t;
  state_t            state;
  logic              sel_trap;
  logic [TRAP_W-1:0] sel_trap_num;
  logic [IRQ_W-1:0]  sel_irq_num;
  logic              sel_any;
  logic [ADDR_W-1:0] next_entry_addr;
  logic [7:0]        next_vector_num;
  logic              fetch_alt;

  // entry address from a slot count above a table base, either table
  function automatic logic [ADDR_W-1:0] slot_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [7:0]        slot,
                                                  input logic              alt);
    slot_addr = base + {15'h0, slot, 1'b0} + (alt ? ALT_OFFSET : 24'h000000);
  endfunction : slot_addr

  // lowest number wins; traps always ahead of interrupts
  always_comb begin
    sel_trap     = 1'b0;
    sel_trap_num = '0;
    sel_irq_num  = '0;
    sel_any      = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pending[i]) begin
        sel_irq_num = IRQ_W'(i);
        sel_any     = 1'b1;
      end
    end
    for (int t = 7; t >= 0; t--) begin
      if (trap_pending[t]) begin
        sel_trap     = 1'b1;
        sel_trap_num = TRAP_W'(t);
        sel_any      = 1'b1;
      end
    end
  end

  vector_address_calc u_calc (
    .is_trap          (sel_trap),
    .trap_num         (sel_trap_num),
    .irq_num          (sel_irq_num),
    .alt_table_select (alt_table_select),
    .entry_addr       (next_entry_addr),
    .vector_num       (next_vector_num)
  );

  // table select bit; reset clears it, unlike busy and fetch_addr, which reset to 1 and to the jump target word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alt_table_select <= 1'b0;
    end else if (ctrl_write) begin
      alt_table_select <= interrupt_control_two[ALT_SELECT_BIT];
    end
  end

  // table of the fetch in flight; the select may be rewritten while it waits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetch_alt <= 1'b0;
    end else if (state == ST_IDLE && service_req && sel_any) begin
      fetch_alt <= alt_table_select;
    end
  end

  // sequencing: reset jump, then service requests
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= ST_RESET_JUMP;
      fetch_addr <= RESET_TARGET_ADDR;
      fetch_req  <= 1'b0;
      pc         <= RESET_ADDR;
      pc_load    <= 1'b0;
      vector_num <= 8'h00;
      busy       <= 1'b1;
    end else begin
      pc_load <= 1'b0;
      unique case (state)
        ST_RESET_JUMP: begin
          // jump target word follows the opcode at zero
          fetch_req  <= 1'b1;
          fetch_addr <= RESET_TARGET_ADDR;
          if (entry_valid && fetch_req) begin
            pc        <= entry_data;
            pc_load   <= 1'b1;
            fetch_req <= 1'b0;
            busy      <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // address latched so a changing pending set cannot move it
          if (service_req && sel_any) begin
            fetch_addr <= next_entry_addr;
            vector_num <= next_vector_num;
            fetch_req  <= 1'b1;
            busy       <= 1'b1;
            state      <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (entry_valid) begin
            pc        <= entry_data;
            pc_load   <= 1'b1;
            fetch_req <= 1'b0;
            busy      <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: begin
          // unused state code: drop any fetch and fall back to idle
          fetch_req <= 1'b0;
          busy      <= 1'b0;
          state     <= ST_IDLE;
        end
      endcase
    end
  end

  // reset entry: pc, pc_load, select and vector number cleared with busy set, then the jump target word is fetched
  AST_RESET_PC: assert property (@(posedge ref_clk) $fell(rst) |-> pc == RESET_ADDR)
    else $error("pc not zero after reset");
  AST_RESET_STATE: assert property (@(posedge ref_clk) rst |=>
    busy && !fetch_req && !pc_load && !alt_table_select && vector_num == 8'h00)
    else $error("reset did not clear state");
  AST_RESET_FETCH: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |=> fetch_req && fetch_addr == RESET_TARGET_ADDR)
    else $error("reset jump target not fetched");

  // table layout: every fetch inside its own table page, below code
  AST_BELOW_CODE: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_req |-> fetch_addr < CODE_START)
    else $error("fetch reached code space");
  AST_ALT_MIRROR: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_FETCH |-> fetch_addr[ADDR_W-1:8] == {15'h0, fetch_alt} && !fetch_addr[0])
    else $error("entry outside its table page");
  AST_ALT_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_req && fetch_alt && state == ST_FETCH |->
      fetch_addr >= TRAP_BASE + ALT_OFFSET && fetch_addr <= ALT_LAST_ADDR)
    else $error("alternate fetch out of table");
  AST_DEF_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_req && !fetch_alt && state == ST_FETCH |->
      fetch_addr >= TRAP_BASE && fetch_addr <= IRQ_LAST_ADDR)
    else $error("default fetch out of table");
  AST_FETCH_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_req && !entry_valid |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request dropped before answer");
  AST_IRQ_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && sel_any && !sel_trap |=>
      fetch_addr == slot_addr(IRQ_BASE, {1'b0, $past(sel_irq_num)},
                              $past(alt_table_select)))
    else $error("interrupt entry address wrong");
  AST_VECTOR: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && sel_any && !sel_trap |=>
      vector_num == {1'b0, $past(sel_irq_num)} + VECTOR_IRQ_OFFSET)
    else $error("vector number not request plus eight");
  AST_PC_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_FETCH && entry_valid |=> pc_load && pc == $past(entry_data))
    else $error("handler address not loaded");
  AST_SELECT: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_write |=> alt_table_select == $past(interrupt_control_two[ALT_SELECT_BIT]))
    else $error("table select not taken");
  AST_TRAP_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && trap_pending[0] |=>
      fetch_addr == slot_addr(TRAP_BASE, 8'h00, $past(alt_table_select)))
    else $error("priority order broken");

  // named sources land on their own request slots
  AST_TIMER_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && trap_pending == 8'h00
      && irq_pending == (NUM_IRQ'(1) << IRQ_TIMER_ONE) |=>
      fetch_addr == slot_addr(IRQ_BASE, 8'h03, $past(alt_table_select))
      && vector_num == 8'h0b)
    else $error("timer one request not at its entry");
  AST_DMA_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && trap_pending == 8'h00
      && irq_pending == (NUM_IRQ'(1) << IRQ_DMA_CHANNEL_ZERO) |=>
      fetch_addr == slot_addr(IRQ_BASE, 8'h04, $past(alt_table_select))
      && vector_num == 8'h0c)
    else $error("dma channel zero request not at its entry");
  AST_SERIAL_RX: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && trap_pending == 8'h00
      && irq_pending == (NUM_IRQ'(1) << IRQ_SERIAL_ONE_RECEIVE) |=>
      fetch_addr == slot_addr(IRQ_BASE, 8'h0b, $past(alt_table_select))
      && vector_num == 8'h13)
    else $error("serial receive request not at its entry");
  AST_CONVERTER_DONE: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_IDLE && service_req && trap_pending == 8'h00
      && irq_pending == (NUM_IRQ'(1) << IRQ_CONVERTER_ONE_DONE) |=>
      fetch_addr == slot_addr(IRQ_BASE, 8'h0d, $past(alt_table_select))
      && vector_num == 8'h15)
    else $error("converter done request not at its entry");
endmodule : interrupt_vector_table_select

// File: common/vector_table_pkg.sv
// constants for the vector fetch address generator
// assumes a 24-bit program address space, word addresses step by two
package vector_table_pkg;
  localparam int          ADDR_W            = 24;
  localparam int          IRQ_W             = 7;
  localparam int          TRAP_W            = 3;
  localparam int          NUM_IRQ           = 118;
  localparam logic [23:0] RESET_ADDR        = 24'h000000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] TRAP_BASE         = 24'h000004;
  localparam logic [23:0] IRQ_BASE          = 24'h000014;
  localparam logic [23:0] IRQ_LAST_ADDR     = 24'h0000fe;
  localparam logic [23:0] ALT_OFFSET        = 24'h000100;
  localparam logic [23:0] ALT_LAST_ADDR     = 24'h0001fe;
  localparam logic [23:0] CODE_START        = 24'h000200;
  localparam logic [7:0]  VECTOR_IRQ_OFFSET = 8'h08;
  localparam int          ALT_SELECT_BIT    = 15;
  // request numbers of named sources
  localparam logic [6:0]  IRQ_EXTERNAL_IRQ_ZERO   = 7'h00;
  localparam logic [6:0]  IRQ_INPUT_CAPTURE_ONE   = 7'h01;
  localparam logic [6:0]  IRQ_OUTPUT_COMPARE_ONE  = 7'h02;
  localparam logic [6:0]  IRQ_TIMER_ONE           = 7'h03;
  localparam logic [6:0]  IRQ_DMA_CHANNEL_ZERO    = 7'h04;
  localparam logic [6:0]  IRQ_SERIAL_ONE_RECEIVE  = 7'h0b;
  localparam logic [6:0]  IRQ_SERIAL_ONE_TRANSMIT = 7'h0c;
  localparam logic [6:0]  IRQ_CONVERTER_ONE_DONE  = 7'h0d;
  // trap slots in table order
  typedef enum logic [2:0] {
    TRAP_RSVD0, TRAP_OSC_FAIL, TRAP_ADDR_ERR, TRAP_STACK_ERR,
    TRAP_MATH_ERR, TRAP_DMA_ERR, TRAP_RSVD6, TRAP_RSVD7
  } trap_t;
endpackage : vector_table_pkg

// File: rtl/vector_address_calc.sv
// combinational entry address for a trap or interrupt, either table
// assumes sources are already arbitrated; irq number below 118
module vector_address_calc
  import vector_table_pkg::*;
(
  input  wire logic              is_trap,
  input  wire logic [TRAP_W-1:0] trap_num,
  input  wire logic [IRQ_W-1:0]  irq_num,
  input  wire logic              alt_table_select,
  output logic      [ADDR_W-1:0] entry_addr,
  output logic      [7:0]        vector_num
);
  logic [ADDR_W-1:0] default_addr;

  // two-address slots, traps then interrupts; same layout in both tables
  always_comb begin
    if (is_trap) begin
      default_addr = TRAP_BASE + {20'h00000, trap_num, 1'b0};
      vector_num   = {5'h00, trap_num};
    end else begin
      default_addr = IRQ_BASE + {16'h0000, irq_num, 1'b0};
      vector_num   = {1'b0, irq_num} + VECTOR_IRQ_OFFSET;
    end
    entry_addr = alt_table_select ? default_addr + ALT_OFFSET : default_addr;
  end
endmodule : vector_address_calc

// File: verification/prog_mem_model.sv
// program memory behind the vector fetch port, answers each fetch once
// assumes fetch_req stands until entry_valid is taken, one clock domain
module prog_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        fetch_req,
  input  wire logic [23:0] fetch_addr,
  input  wire logic [3:0]  wait_cycles,
  output logic             entry_valid,
  output logic      [23:0] entry_data
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter logic [23:0] MASK = 24'hc30000;
  logic [3:0] cnt;
  initial begin
    entry_valid = 1'b0;
    entry_data  = 24'h000000;
    cnt         = 4'h0;
  end
  // stall wait_cycles, then one valid pulse; data word 0x2 is the jump target
  always @(posedge ref_clk) begin
    if (fetch_req && !entry_valid && cnt == wait_cycles) begin
      entry_valid <= 1'b1;
      entry_data  <= fetch_addr ^ MASK;
      cnt         <= 4'h0;
    end else begin
      entry_valid <= 1'b0;
      entry_data  <= ~entry_data; // stale word inverted every cycle between answers
      cnt         <= (fetch_req && !entry_valid) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : prog_mem_model

// File: verification/tb_interrupt_vector_table_select.sv
// self-checking bench for the vector fetch address generator
// assumes prog_mem_model answers fetches; pc expected as address xor mask
module tb_interrupt_vector_table_select;
  import vector_table_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] MASK = 24'hc30000;
  logic ref_clk = 1'b0, rst = 1'b1, ctrl_write = 1'b0, service_req = 1'b0;
  logic [15:0] interrupt_control_two = 16'h0000;
  logic [NUM_IRQ-1:0] irq_pending = '0;
  logic [7:0] trap_pending = 8'h00, vector_num;
  logic [3:0] wait_cycles = 4'h0;
  logic entry_valid, alt_table_select, fetch_req, pc_load, busy;
  logic [23:0] entry_data, fetch_addr, pc;
  int fails = 0, num_checks = 0, cycles = 0;
  int named[7] = '{1, 2, 3, 4, 11, 12, 13};
  interrupt_vector_table_select dut (.ref_clk(ref_clk), .rst(rst), .ctrl_write(ctrl_write),
    .interrupt_control_two(interrupt_control_two), .irq_pending(irq_pending),
    .trap_pending(trap_pending), .service_req(service_req), .entry_valid(entry_valid),
    .entry_data(entry_data), .alt_table_select(alt_table_select), .fetch_addr(fetch_addr),
    .fetch_req(fetch_req), .pc(pc), .pc_load(pc_load), .vector_num(vector_num), .busy(busy));
  prog_mem_model #(.MASK(MASK)) mem (.ref_clk(ref_clk), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .wait_cycles(wait_cycles), .entry_valid(entry_valid),
    .entry_data(entry_data));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // bounded wait for the one-cycle load pulse, then the loaded value
  task automatic wait_load(input logic [23:0] addr);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("pc_load", 24'h000001, 24'(pc_load));
    chk("pc", addr ^ MASK, pc);
    chk("busy", 24'h000000, 24'(busy));
    chk("fetch_req", 24'h000000, 24'(fetch_req));
  endtask : wait_load
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("pc", 24'h000000, pc);
    chk("alt_table_select", 24'h000000, 24'(alt_table_select));
    chk("busy", 24'h000001, 24'(busy));
    chk("vector_num", 24'h000000, 24'(vector_num));
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("fetch_req", 24'h000001, 24'(fetch_req));
    chk("fetch_addr", 24'h000002, fetch_addr);
    wait_load(24'h000002);
  endtask : do_reset
  task automatic serve(input logic [NUM_IRQ-1:0] irq, input logic [7:0] trap,
                       input logic [23:0] addr, input logic [7:0] vec);
    @(posedge ref_clk);
    irq_pending <= irq;
    trap_pending <= trap;
    service_req <= 1'b1;
    @(posedge ref_clk);
    service_req <= 1'b0;
    #1;
    chk("fetch_req", 24'h000001, 24'(fetch_req));
    chk("busy", 24'h000001, 24'(busy));
    chk("fetch_addr", addr, fetch_addr);
    chk("vector_num", 24'(vec), 24'(vector_num));
    wait_load(addr);
  endtask : serve
  task automatic set_sel(input logic [15:0] word);
    @(posedge ref_clk);
    ctrl_write <= 1'b1;
    interrupt_control_two <= word;
    @(posedge ref_clk);
    ctrl_write <= 1'b0;
    #1;
    chk("alt_table_select", 24'(word[15]), alt_table_select);
  endtask : set_sel
  // nothing pending: the request is refused and no fetch starts
  task automatic idle_req();
    @(posedge ref_clk);
    irq_pending <= '0;
    trap_pending <= 8'h00;
    service_req <= 1'b1;
    @(posedge ref_clk);
    service_req <= 1'b0;
    #1;
    chk("fetch_req", 24'h000000, 24'(fetch_req));
    chk("busy", 24'h000000, 24'(busy));
  endtask : idle_req
  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    do_reset();
    serve(118'h1, 8'h00, 24'h000014, 8'h08);
    serve(118'h1 << 117, 8'h00, 24'h0000fe, 8'h7d);
    foreach (named[i]) serve(118'h1 << named[i], 8'h00, 24'(20 + 2 * named[i]), 8'(named[i] + 8));
    serve(118'h28, 8'h00, 24'h00001a, 8'h0b);
    idle_req();
    wait_cycles <= 4'h3; // slow memory from here on
    serve(118'h1, 8'h24, 24'h000008, 8'h02);
    for (int t = 0; t < 8; t++) serve('0, 8'(1 << t), 24'(4 + 2 * t), 8'(t));
    set_sel(16'h8000);
    serve(118'h1, 8'h00, 24'h000114, 8'h08);
    serve(118'h1 << 117, 8'h00, 24'h0001fe, 8'h7d);
    serve('0, 8'h08, 24'h00010a, 8'h03);
    set_sel(16'h7fff);
    serve(118'h1 << 13, 8'h00, 24'h00002e, 8'h15);
    set_sel(16'h8000);
    do_reset();
    stop_test();
  end
endmodule : tb_interrupt_vector_table_select
